// *** core/loop_status_defs.svh ***
// constants and field layout for the loop four status word
// Overview of operation
// - set save-done when nonvolatile copy finishes
// - host save request rise starts write
// - save request set clears save-done
// - save-done clear after power-up
// - sensor fault: absent, open, over span
// - unused bits 13, 7:5, 2 read zero
// - fatal fault on junction or watchdog
// - standby until first refresh after restart
// - set new-constants flag on autotune result
// - flag clears once constants transferred
// - setting error on invalid host setting
// - stopped bit set while control halted
// - control output bit mirrors output
// - autotune bit set while tuning runs
// - alarm bits follow alarm range checks
// - reload command clears new-constants flag
// - host stop bit drives stopped status
`ifndef LOOP_STATUS_DEFS_SVH
`define LOOP_STATUS_DEFS_SVH
`define LSW_OFFSET 8'h13
`define LSW_RESET 16'h0000
`define LSW_SAVE_DONE 15
`define LSW_SENSOR 14
`define LSW_FATAL 12
`define LSW_STANDBY 11
`define LSW_NEW_PID 10
`define LSW_SET_ERR 9
`define LSW_STOPPED 8
`define LSW_CTRL_OUT 4
`define LSW_AUTOTUNE 3
`define LSW_ALARM1 1
`define LSW_ALARM2 0
`define LSW_UNUSED_MASK 16'h20E4
`endif

// *** core/loop_status_pkg.sv ***
// types for the loop four status word
`default_nettype none
package loop_status_pkg;
	typedef logic [15:0] word_t;
	typedef enum logic [1:0] {save_idle, save_busy, save_done} save_state_e;
endpackage
`default_nettype wire

// *** core/pin_sync.sv ***
// two flip-flop synchroniser, one per bit
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clock or posedge rst)
			begin
				if (rst)
				begin
					meta_q[i] <= 1'b0;
					sync_out[i] <= 1'b0;
				end
				else
				begin
					meta_q[i] <= async_in[i];
					sync_out[i] <= meta_q[i];
				end
			end
		end
	endgenerate
endmodule // pin_sync
`default_nettype wire

// *** core/temp_loop_status_word.sv ***
// status word generator for control loop four
`include "loop_status_defs.svh"
`default_nettype none
module temp_loop_status_word (
	input wire logic clock,
	input wire logic rst,
	input wire logic io_refresh,
	input wire logic save_request_bit,
	input wire logic reload_tuning_constants_bit,
	input wire logic stop_command_bit,
	input wire logic nvm_write_done,
	input wire logic sensor_absent,
	input wire logic sensor_open,
	input wire logic input_over_span,
	input wire logic junction_fault,
	input wire logic host_watchdog_timeout,
	input wire logic tuning_result,
	input wire logic constants_sent,
	input wire logic setting_invalid,
	input wire logic control_output,
	input wire logic tuning_running,
	input wire logic in_first_alarm_range,
	input wire logic in_second_alarm_range,
	input wire logic [7:0] reg_addr,
	output logic nvm_write_start,
	output loop_status_pkg::word_t reg_rdata,
	output loop_status_pkg::word_t loop_four_status_word
);
	// ========================================
	// pin synchronisers
	// ========================================
	localparam int NPIN = 12;
	logic [NPIN-1:0] pins_sync;
	pin_sync #(.WIDTH(NPIN)) u_sync (
		.clock(clock),
		.rst(rst),
		.async_in({nvm_write_done, sensor_absent, sensor_open,
			input_over_span, junction_fault, tuning_result,
			constants_sent, setting_invalid, control_output,
			tuning_running, in_first_alarm_range,
			in_second_alarm_range}),
		.sync_out(pins_sync)
	);
	logic done_s, absent_s, open_s, span_s, junc_s, result_s;
	logic sent_s, inval_s, out_s, tune_s, al1_s, al2_s;
	assign {done_s, absent_s, open_s, span_s, junc_s, result_s,
		sent_s, inval_s, out_s, tune_s, al1_s, al2_s} = pins_sync;

	// ========================================
	// save sequence
	// ========================================
	loop_status_pkg::save_state_e save_q;
	logic save_req_q, reload_q;
	logic save_rise, reload_rise;
	assign save_rise = save_request_bit && !save_req_q;
	assign reload_rise = reload_tuning_constants_bit && !reload_q;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			save_req_q <= 1'b0;
			reload_q <= 1'b0;
		end
		else
		begin
			save_req_q <= save_request_bit;
			reload_q <= reload_tuning_constants_bit;
		end
	end
	// save-done off from reset until a requested save finishes
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			save_q <= loop_status_pkg::save_idle;
		else
		begin
			case (save_q)
				loop_status_pkg::save_idle:
					if (save_rise)
						save_q <= loop_status_pkg::save_busy;
				loop_status_pkg::save_busy:
					if (done_s)
						save_q <= loop_status_pkg::save_done;
				loop_status_pkg::save_done:
					if (save_rise)
						save_q <= loop_status_pkg::save_busy;
				default:
					save_q <= loop_status_pkg::save_idle;
			endcase
		end
	end
	assign nvm_write_start = save_rise;

	// ========================================
	// tuning constants flag
	// ========================================
	logic new_tuning_constants_flag_q;
	// a fresh result beats a simultaneous reload so it is not lost
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			new_tuning_constants_flag_q <= 1'b0;
		else if (result_s)
			new_tuning_constants_flag_q <= 1'b1;
		else if (reload_rise || sent_s)
			new_tuning_constants_flag_q <= 1'b0;
	end

	// ========================================
	// standby until first refresh
	// ========================================
	logic standby_q;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			standby_q <= 1'b1;
		else if (io_refresh)
			standby_q <= 1'b0;
	end

	// ========================================
	// word assembly and snapshot
	// ========================================
	loop_status_pkg::word_t live_d;
	always_comb
	begin
		live_d = `LSW_RESET;
		live_d[`LSW_SAVE_DONE] = (save_q == loop_status_pkg::save_done);
		live_d[`LSW_SENSOR] = absent_s || open_s || span_s;
		live_d[`LSW_FATAL] = junc_s || host_watchdog_timeout;
		live_d[`LSW_STANDBY] = standby_q;
		live_d[`LSW_NEW_PID] = new_tuning_constants_flag_q;
		live_d[`LSW_SET_ERR] = inval_s;
		live_d[`LSW_STOPPED] = stop_command_bit;
		live_d[`LSW_CTRL_OUT] = out_s;
		live_d[`LSW_AUTOTUNE] = tune_s;
		live_d[`LSW_ALARM1] = al1_s;
		live_d[`LSW_ALARM2] = al2_s;
	end
	// standby is shown in the snapshot taken at the first refresh
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			loop_four_status_word <= `LSW_RESET;
		else if (io_refresh)
			loop_four_status_word <= live_d;
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			reg_rdata <= `LSW_RESET;
		else if (reg_addr == `LSW_OFFSET)
			reg_rdata <= loop_four_status_word;
		else
			reg_rdata <= `LSW_RESET;
	end

	// ========================================
	// assertions
	// ========================================
	a_unused_zero: assert property (@(posedge clock) disable iff (rst)
		(loop_four_status_word & `LSW_UNUSED_MASK) == 16'h0000)
		else $error("unused status bits not zero");
	a_save_start: assert property (@(posedge clock) disable iff (rst)
		$rose(save_request_bit) |-> nvm_write_start)
		else $error("save rise did not start write");
	a_start_pulse: assert property (@(posedge clock) disable iff (rst)
		nvm_write_start |=> !nvm_write_start)
		else $error("write start longer than one cycle");
	a_save_clear: assert property (@(posedge clock) disable iff (rst)
		save_rise |=> save_q != loop_status_pkg::save_done)
		else $error("save-done not cleared by request");
	a_save_done: assert property (@(posedge clock) disable iff (rst)
		save_q == loop_status_pkg::save_busy && done_s && !save_rise
		|=> save_q == loop_status_pkg::save_done)
		else $error("save completion not flagged");
	a_idle_nodone: assert property (@(posedge clock) disable iff (rst)
		save_q == loop_status_pkg::save_idle && !save_rise
		|=> save_q == loop_status_pkg::save_idle)
		else $error("save-done without request");
	a_standby_drop: assert property (@(posedge clock) disable iff (rst)
		io_refresh |=> !standby_q && loop_four_status_word[`LSW_STANDBY]
		== $past(standby_q))
		else $error("standby not handled at refresh");
	a_pid_set: assert property (@(posedge clock) disable iff (rst)
		result_s |=> new_tuning_constants_flag_q)
		else $error("new constants flag not set");
	a_pid_reload: assert property (@(posedge clock) disable iff (rst)
		reload_rise && !result_s |=> !new_tuning_constants_flag_q)
		else $error("reload did not clear flag");
	a_snapshot: assert property (@(posedge clock) disable iff (rst)
		!io_refresh |=> $stable(loop_four_status_word))
		else $error("word changed between refreshes");
	a_stop_mirror: assert property (@(posedge clock) disable iff (rst)
		io_refresh |=> loop_four_status_word[`LSW_STOPPED]
		== $past(stop_command_bit))
		else $error("stopped bit wrong");
	a_sensor_flag: assert property (@(posedge clock) disable iff (rst)
		io_refresh |=> loop_four_status_word[`LSW_SENSOR]
		== $past(absent_s || open_s || span_s))
		else $error("sensor fault bit wrong");
	a_fatal_flag: assert property (@(posedge clock) disable iff (rst)
		io_refresh |=> loop_four_status_word[`LSW_FATAL]
		== $past(junc_s || host_watchdog_timeout))
		else $error("fatal fault bit wrong");
	a_done_word: assert property (@(posedge clock) disable iff (rst)
		io_refresh |=> loop_four_status_word[`LSW_SAVE_DONE]
		== $past(save_q == loop_status_pkg::save_done))
		else $error("save-done bit wrong");
	// read port lags the snapshot by one edge
	a_read_back: assert property (@(posedge clock) disable iff (rst)
		reg_addr == `LSW_OFFSET |=> reg_rdata
		== $past(loop_four_status_word))
		else $error("read data not the status word");
	c_save_cycle: cover property (@(posedge clock) disable iff (rst)
		save_q == loop_status_pkg::save_busy ##[1:50]
		save_q == loop_status_pkg::save_done);
	c_reload: cover property (@(posedge clock) disable iff (rst)
		new_tuning_constants_flag_q ##1 reload_rise);
	c_refresh: cover property (@(posedge clock) disable iff (rst)
		standby_q ##1 io_refresh);
	c_pid_clash: cover property (@(posedge clock) disable iff (rst)
		result_s && reload_rise);
endmodule // temp_loop_status_word
`default_nettype wire

// *** dv/host_refresh_model.sv ***
// host side model: periodic refresh strobe
`default_nettype none
module host_refresh_model #(
	parameter int PERIOD = 8
) (
	input wire logic clock,
	input wire logic rst,
	output logic io_refresh
);
	timeunit 1ns;
	timeprecision 1ns;
	int count_q;
	// ========================================
	// refresh pacing, free running like a scan
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			count_q <= 0;
			io_refresh <= 1'b0;
		end
		else
		begin
			count_q <= (count_q == PERIOD - 1) ? 0 : count_q + 1;
			io_refresh <= (count_q == PERIOD - 1);
		end
	end
endmodule // host_refresh_model
`default_nettype wire

// *** dv/temp_loop_status_word_bench.sv ***
// self-checking bench for the loop four status word
`default_nettype none
module temp_loop_status_word_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst, io_refresh, save_request_bit, reload_tuning_constants_bit;
	logic stop_command_bit, nvm_write_done, sensor_absent, sensor_open;
	logic input_over_span, junction_fault, host_watchdog_timeout, tuning_result;
	logic constants_sent, setting_invalid, control_output, tuning_running;
	logic in_first_alarm_range, in_second_alarm_range, nvm_write_start;
	logic [7:0] reg_addr;
	loop_status_pkg::word_t reg_rdata, loop_four_status_word;
	logic exp_done, exp_pid;
	int seed = 67459;
	int miscompares = 0;
	int comparisons = 0;
	temp_loop_status_word dut_u (.clock, .rst, .io_refresh, .save_request_bit,
		.reload_tuning_constants_bit, .stop_command_bit, .nvm_write_done,
		.sensor_absent, .sensor_open, .input_over_span, .junction_fault,
		.host_watchdog_timeout, .tuning_result, .constants_sent, .setting_invalid,
		.control_output, .tuning_running, .in_first_alarm_range,
		.in_second_alarm_range, .reg_addr, .nvm_write_start, .reg_rdata,
		.loop_four_status_word);
	host_refresh_model #(.PERIOD(8)) host_u (.clock, .rst, .io_refresh);
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// ========================================
	// helpers
	task automatic report_and_stop;
		if (miscompares == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic check_word(loop_status_pkg::word_t got, exp, string what);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(logic got, exp, string what);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %0t %s got %b", $time, what, got);
		end
	endtask
	function automatic loop_status_pkg::word_t expect_word(logic standby);
		loop_status_pkg::word_t w;
		w = 16'h0000;
		w[15] = exp_done;
		w[14] = sensor_absent | sensor_open | input_over_span;
		w[12] = junction_fault | host_watchdog_timeout;
		w[11] = standby;
		w[10] = exp_pid;
		w[9] = setting_invalid;
		w[8] = stop_command_bit;
		w[4] = control_output;
		w[3] = tuning_running;
		w[1] = in_first_alarm_range;
		w[0] = in_second_alarm_range;
		return w;
	endfunction
	// settle past the synchronisers, then catch one refresh
	task automatic refresh_check(logic standby);
		loop_status_pkg::word_t w;
		tick(4);
		for (int i = 0; i < 20 && !io_refresh; i++)
			tick(1);
		if (!io_refresh)
		begin
			miscompares++;
			$display("mismatch %0t refresh timeout", $time);
			report_and_stop();
		end
		tick(2);
		w = expect_word(standby);
		check_word(loop_four_status_word, w, "word");
		check_word(reg_rdata, reg_addr == 8'h13 ? w : 16'h0000, "read");
	endtask
	// ========================================
	// main sequence
	initial
	begin
		{sensor_absent, sensor_open, input_over_span, junction_fault,
			host_watchdog_timeout, setting_invalid, stop_command_bit, control_output,
			tuning_running, in_first_alarm_range, in_second_alarm_range,
			tuning_result, constants_sent, reload_tuning_constants_bit,
			save_request_bit, nvm_write_done, exp_done, exp_pid} = 18'h00000;
		reg_addr = 8'h13;
		rst = 1'b1;
		tick(3);
		rst = 1'b0;
		nvm_write_done = 1'b1;
		refresh_check(1'b1);
		nvm_write_done = 1'b0;
		refresh_check(1'b0);
		for (int s = 0; s < 2; s++)
		begin
			save_request_bit = 1'b1;
			exp_done = 1'b0;
			#1 check_bit(nvm_write_start, 1'b1, "start");
			tick(1);
			check_bit(nvm_write_start, 1'b0, "start pulse");
			refresh_check(1'b0);
			nvm_write_done = 1'b1;
			exp_done = 1'b1;
			refresh_check(1'b0);
			nvm_write_done = 1'b0;
			save_request_bit = 1'b0;
			tick(1);
		end
		for (int i = 0; i < 40; i++)
		begin
			{sensor_absent, sensor_open, input_over_span, junction_fault,
				host_watchdog_timeout, setting_invalid, stop_command_bit,
				control_output, tuning_running, in_first_alarm_range,
				in_second_alarm_range, tuning_result, constants_sent} =
				13'($random(seed));
			reg_addr = ($random(seed) & 1) ? 8'h13 : 8'($random(seed));
			// reload moves after the synced result, so no race with a set
			tick(3);
			if (tuning_result)
				exp_pid = 1'b1;
			else if (constants_sent || !reload_tuning_constants_bit)
				exp_pid = constants_sent ? 1'b0 : exp_pid;
			reload_tuning_constants_bit = ~reload_tuning_constants_bit;
			if (!tuning_result && reload_tuning_constants_bit)
				exp_pid = 1'b0;
			refresh_check(1'b0);
		end
		{tuning_result, sensor_absent, reload_tuning_constants_bit} = 3'h0;
		rst = 1'b1;
		tick(2);
		check_word(loop_four_status_word, 16'h0000, "reset");
		rst = 1'b0;
		{exp_done, exp_pid} = 2'h0;
		refresh_check(1'b1);
		report_and_stop();
	end
endmodule // temp_loop_status_word_bench
`default_nettype wire
